// ---- design/dyn_odt_pkg.sv ----
// Constants for the dynamic termination control block.
// Assumes mode register fields arrive on a 16-bit address bus.
package dyn_odt_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int LAT_W  = 5;
  localparam int CNT_W  = 6;
  localparam int HIST_D = 32;

  // ------------------------------------------------------------
  // Mode register select and field positions
  // ------------------------------------------------------------
  localparam logic [1:0] MRS_SEL_MR1 = 2'h1;
  localparam logic [1:0] MRS_SEL_MR2 = 2'h2;
  localparam int MR1_NOM_B2  = 9;
  localparam int MR1_NOM_B1  = 6;
  localparam int MR1_NOM_B0  = 2;
  localparam int MR2_WR_B1   = 10;
  localparam int MR2_WR_B0   = 9;
  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Latency figures in command clock cycles
  // ------------------------------------------------------------
  localparam logic [LAT_W-1:0] ODT_LAT_SUB = 5'h02;
  localparam logic [CNT_W-1:0] CWN4_ADD    = 6'h04;
  localparam logic [CNT_W-1:0] CWN8_ADD    = 6'h06;
  localparam logic [CNT_W-1:0] CNT_FIRST   = 6'h01;

endpackage

// ---- design/odt_delay_line.sv ----
// Variable-tap shift register delaying the registered ODT level.
// Assumes tap select is at least one and below the depth.
`timescale 1ns/1ps
`default_nettype none
module odt_delay_line #(
  parameter int DEPTH = dyn_odt_pkg::HIST_D
) (
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  input  wire logic                          odt_i,
  input  wire logic [dyn_odt_pkg::LAT_W-1:0] tap_i,
  output logic                               odt_o
);
  import dyn_odt_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] hist;
  } dl_state_t;

  dl_state_t s_q;
  dl_state_t s_d;

  // ------------------------------------------------------------
  // Shift and tap
  // ------------------------------------------------------------
  // Bit k holds the level sampled k+1 edges ago
  always_comb begin
    s_d = s_q;
    s_d.hist = {s_q.hist[DEPTH-2:0], odt_i};
  end

  assign odt_o = s_q.hist[tap_i - LAT_W'(1)];

  // Register
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ---- design/dyn_odt_ctrl.sv ----
// Dynamic on-die termination control for a DDR3 style device.
// Assumes command decode supplies one-cycle write and mode register
// set pulses, all on the command clock.
//
// Operation
// - Dynamic mode is active when MR2 bit A9 or A10 is one.
// - Nominal strength comes from MR1 bits A9, A6 and A2.
// - Write strength comes from MR2 bits A10 and A9.
// - Without writes nominal strength is used and ODT gates on/off.
// - A write in dynamic mode selects write strength ODTLcnw later.
// - Nominal strength returns ODTLcwn8 or ODTLcwn4 after a write.
// - Dynamic mode is unsupported with the DLL off; dll_off_i withholds it, MR2 is kept.
// - Termination turns on and off WL-2 cycles after the ODT level.
// - Nominal to write strength happens WL-2 cycles after a write.
// - Burst chop 4 restores nominal 4 plus turn-off latency later.
// - Burst length 8 restores nominal 6 plus turn-off latency later.
// - ODT latencies equal write latency plus additive latency less 2.
// - In self-refresh the ODT pin is ignored and termination is off.
`timescale 1ns/1ps
`default_nettype none
module dyn_odt_ctrl (
  input  wire logic                           clock_i,
  input  wire logic                           rstn_i,
  input  wire logic                           odt_i,
  input  wire logic                           wr_cmd_i,
  input  wire logic                           bc4_i,
  input  wire logic                           mrs_i,
  input  wire logic [1:0]                     mrs_sel_i,
  input  wire logic [dyn_odt_pkg::ADDR_W-1:0] mrs_addr_i,
  input  wire logic [3:0]                     cwl_i,
  input  wire logic [3:0]                     al_i,
  input  wire logic                           self_refresh_i,
  input  wire logic                           dll_off_i,
  output logic                                rtt_en_o,
  output logic                                rtt_sel_wr_o,
  output logic [2:0]                          rtt_nom_o,
  output logic [1:0]                          rtt_wr_o,
  output logic                                dyn_en_o
);
  import dyn_odt_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] mr1;
    logic [ADDR_W-1:0] mr2;
    logic              dyn_en;
    logic              rtt_en;
    logic              sel_wr;
    logic              busy;
    logic              bc4;
    logic [CNT_W-1:0]  cnt;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [LAT_W-1:0] lat;
  logic [CNT_W-1:0] cwn_end;
  logic             odt_live;
  logic             odt_tap;
  logic             wr_tap;

  // Mode register set aimed at one register
  function automatic logic mrs_hit(input logic       strobe,
                                   input logic [1:0] sel,
                                   input logic [1:0] want);
    mrs_hit = strobe && (sel == want);
  endfunction

  // ------------------------------------------------------------
  // Latency derivation
  // ------------------------------------------------------------
  // Turn-on, turn-off and strength change share one latency
  assign lat = LAT_W'(cwl_i) + LAT_W'(al_i) - ODT_LAT_SUB;
  // Return point after the newest write
  assign cwn_end = CNT_W'(lat) + (s_q.bc4 ? CWN4_ADD : CWN8_ADD);
  // Pin ignored in self-refresh
  assign odt_live = odt_i & ~self_refresh_i;

  // ------------------------------------------------------------
  // ODT pin delay
  // ------------------------------------------------------------
  odt_delay_line #(
    .DEPTH (HIST_D)
  ) u_delay (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .odt_i   (odt_live),
    .tap_i   (lat),
    .odt_o   (odt_tap)
  );

  // Write delay, so a later write cannot push back an earlier switch
  odt_delay_line #(
    .DEPTH (HIST_D)
  ) u_wr_delay (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .odt_i   (wr_cmd_i),
    .tap_i   (lat),
    .odt_o   (wr_tap)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Mode register capture
    if (mrs_hit(mrs_i, mrs_sel_i, MRS_SEL_MR1)) begin
      s_d.mr1 = mrs_addr_i;
    end
    if (mrs_hit(mrs_i, mrs_sel_i, MRS_SEL_MR2)) begin
      s_d.mr2 = mrs_addr_i;
    end
    // Dynamic enable, withheld while the DLL is off
    s_d.dyn_en = (s_q.mr2[MR2_WR_B1] | s_q.mr2[MR2_WR_B0])
                 & ~dll_off_i;
    // Termination gate follows the delayed pin
    s_d.rtt_en = odt_tap & ~self_refresh_i;
    // Write hold window counts from the newest write
    if (s_q.busy) begin
      s_d.cnt = s_q.cnt + CNT_FIRST;
    end
    if (s_q.busy && s_q.cnt == cwn_end) begin
      s_d.sel_wr = 1'b0;
      s_d.busy   = 1'b0;
    end
    // Newest write restarts the window and keeps write strength
    if (wr_cmd_i) begin
      s_d.busy   = 1'b1;
      s_d.cnt    = CNT_FIRST;
      s_d.bc4    = bc4_i;
      s_d.sel_wr = s_q.sel_wr;
    end
    // Every write, older ones too, switches strength L edges later in dynamic mode
    if (wr_tap && s_q.dyn_en) begin
      s_d.sel_wr = 1'b1;
    end
    // Nominal only when dynamic mode is off
    if (!s_q.dyn_en) begin
      s_d.sel_wr = 1'b0;
    end
  end

  // Register
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_q.mr1    <= MR_RESET;
      s_q.mr2    <= MR_RESET;
      s_q.dyn_en <= 1'b0;
      s_q.rtt_en <= 1'b0;
      s_q.sel_wr <= 1'b0;
      s_q.busy   <= 1'b0;
      s_q.bc4    <= 1'b0;
      s_q.cnt    <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rtt_en_o     = s_q.rtt_en;
  assign rtt_sel_wr_o = s_q.sel_wr;
  assign rtt_nom_o    = {s_q.mr1[MR1_NOM_B2], s_q.mr1[MR1_NOM_B1],
                         s_q.mr1[MR1_NOM_B0]};
  assign rtt_wr_o     = {s_q.mr2[MR2_WR_B1], s_q.mr2[MR2_WR_B0]};
  assign dyn_en_o     = s_q.dyn_en;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  AST_DYN_EN: assert property (
    dyn_en_o |-> $past(rtt_wr_o) != 2'h0)
    else $error("dynamic mode on with zero write field");
  AST_DLL_OFF: assert property (
    dll_off_i |=> !dyn_en_o ##1 !rtt_sel_wr_o)
    else $error("dynamic mode kept with DLL off");
  AST_NOM_FIELD: assert property (
    mrs_hit(mrs_i, mrs_sel_i, MRS_SEL_MR1) |=> rtt_nom_o ==
      {$past(mrs_addr_i[MR1_NOM_B2]), $past(mrs_addr_i[MR1_NOM_B1]),
       $past(mrs_addr_i[MR1_NOM_B0])})
    else $error("nominal field not taken");
  AST_WR_FIELD: assert property (
    mrs_hit(mrs_i, mrs_sel_i, MRS_SEL_MR2) |=> rtt_wr_o ==
      {$past(mrs_addr_i[MR2_WR_B1]), $past(mrs_addr_i[MR2_WR_B0])})
    else $error("write field not taken");
  AST_SR_OFF: assert property (
    self_refresh_i |=> !rtt_en_o)
    else $error("termination on in self-refresh");
  AST_NOM_IDLE: assert property (
    !s_q.busy && !wr_cmd_i |=> !rtt_sel_wr_o)
    else $error("write strength without a write");
  AST_CNW: assert property (
    s_q.busy && s_q.cnt == CNT_W'(lat) && dyn_en_o |=> rtt_sel_wr_o)
    else $error("write strength late");
  AST_CWN4: assert property (
    s_q.busy && s_q.bc4 && s_q.cnt == CNT_W'(lat) + CWN4_ADD && !wr_cmd_i
      |=> !rtt_sel_wr_o)
    else $error("chop 4 nominal return wrong");
  AST_CWN8: assert property (
    s_q.busy && !s_q.bc4 && s_q.cnt == CNT_W'(lat) + CWN8_ADD && !wr_cmd_i
      |=> !rtt_sel_wr_o)
    else $error("burst 8 nominal return wrong");
  AST_REWRITE: assert property (
    wr_cmd_i && rtt_sel_wr_o && dyn_en_o |=> rtt_sel_wr_o)
    else $error("write strength dropped by a newer write");
  AST_NOM_ONLY: assert property (
    !dyn_en_o |=> !rtt_sel_wr_o)
    else $error("write strength with dynamic mode off");

  COV_WR_SWITCH: cover property ($rose(rtt_sel_wr_o));
  COV_ODT_ON:    cover property ($rose(rtt_en_o));
  COV_REWRITE:   cover property (wr_cmd_i && rtt_sel_wr_o);
  COV_CHOP4:     cover property (wr_cmd_i && bc4_i && dyn_en_o);

endmodule
`default_nettype wire

// ---- tb/odt_ctrl_model.sv ----
// Controller model: raises ODT with each write and holds it.
// Assumes go_i and bc4_sel_i are driven off the rising edge.
`timescale 1ns/1ps
`default_nettype none
module odt_ctrl_model (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic go_i,
  input  wire logic bc4_sel_i,
  output logic      odt_o,
  output logic      wr_cmd_o,
  output logic      bc4_o
);
  logic [2:0] cnt_q;
  // ------------------------------------------------------------
  // Write issue and ODT hold
  // ------------------------------------------------------------
  // A new write restarts the hold, so ODT never drops too early
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      odt_o    <= 1'b0;
      wr_cmd_o <= 1'b0;
      bc4_o    <= 1'b0;
      cnt_q    <= 3'h0;
    end else if (go_i) begin
      odt_o    <= 1'b1;
      wr_cmd_o <= 1'b1;
      bc4_o    <= bc4_sel_i;
      cnt_q    <= bc4_sel_i ? 3'h3 : 3'h5;
    end else begin
      wr_cmd_o <= 1'b0;
      if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else begin
        odt_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/dyn_odt_ctrl_tb_top.sv ----
// Bench for the dynamic termination control block.
// Assumes the controller model drives ODT and write commands.
`timescale 1ns/1ps
`default_nettype none
module dyn_odt_ctrl_tb_top;
  import dyn_odt_pkg::*;
  typedef logic [22:0] row_t;
  logic        clock_i, rstn_i, go, bc4_sel, odt, wr_cmd, bc4, mrs, sr;
  logic        dll_off, rtt_en, rtt_sel_wr, dyn_en;
  logic [1:0]  mrs_sel, rtt_wr;
  logic [15:0] mrs_addr;
  logic [3:0]  cwl, al;
  logic [2:0]  rtt_nom;
  int          miscompares = 0;
  int          n_compared = 0;
  int          l;
  // Rows: select, address, nominal field, write field
  row_t rows [11] = '{{2'h1, 16'h0004, 3'h1, 2'h0},
    {2'h1, 16'h0040, 3'h2, 2'h0}, {2'h1, 16'h0200, 3'h4, 2'h0},
    {2'h1, 16'hfdbb, 3'h0, 2'h0}, {2'h1, 16'h0244, 3'h7, 2'h0},
    {2'h2, 16'h0200, 3'h7, 2'h1}, {2'h2, 16'h0400, 3'h7, 2'h2},
    {2'h3, 16'h0000, 3'h7, 2'h2}, {2'h0, 16'h0000, 3'h7, 2'h2},
    {2'h2, 16'hf9ff, 3'h7, 2'h0}, {2'h2, 16'h0600, 3'h7, 2'h3}};
  // Latency cases: write latency, additive latency, chop, 2nd write
  logic [11:0] runs [5] = '{{4'h5, 4'h0, 4'h0}, {4'h5, 4'h0, 4'h8},
    {4'h6, 4'h2, 4'h0}, {4'h6, 4'h2, 4'hb}, {4'h5, 4'h0, 4'h2}};

  odt_ctrl_model ctrl_u (.clock_i(clock_i), .rstn_i(rstn_i), .go_i(go),
    .bc4_sel_i(bc4_sel), .odt_o(odt), .wr_cmd_o(wr_cmd), .bc4_o(bc4));
  dyn_odt_ctrl dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .odt_i(odt),
    .wr_cmd_i(wr_cmd), .bc4_i(bc4), .mrs_i(mrs), .mrs_sel_i(mrs_sel),
    .mrs_addr_i(mrs_addr), .cwl_i(cwl), .al_i(al), .self_refresh_i(sr),
    .dll_off_i(dll_off), .rtt_en_o(rtt_en), .rtt_sel_wr_o(rtt_sel_wr),
    .rtt_nom_o(rtt_nom), .rtt_wr_o(rtt_wr), .dyn_en_o(dyn_en));

  // Clock, 50 ns period
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tick();
    @(posedge clock_i);
    #5;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send_mrs(input logic [1:0] s, input logic [15:0] a);
    mrs = 1'b1;
    mrs_sel = s;
    mrs_addr = a;
    tick();
    mrs = 1'b0;
  endtask
  // One write (or two, gap edges apart) with ODT held by the model
  task automatic run(input logic b, input int gap, input logic dyn,
                     input logic srf);
    int w;
    w = b ? 4 : 6;
    bc4_sel = b;
    go = 1'b1;
    tick();
    go = 1'b0;
    for (int k = 0; k < gap + l + w + 3; k++) begin
      tick();
      go = (k + 2 == gap);
      chk(rtt_en, !srf && k >= l && k < gap + w + l);
      if (!srf) chk(rtt_sel_wr, dyn && k >= l && k < gap + l + w);
    end
  endtask
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rstn_i, go, bc4_sel, mrs, mrs_sel, mrs_addr, al, sr, dll_off} = '0;
    cwl = 4'h5;
    l = 3;
    repeat (16) tick();
    rstn_i = 1'b1;
    chk({rtt_en, rtt_sel_wr, dyn_en}, 3'h0);
    // Mode register fields and dynamic enable
    foreach (rows[i]) begin
      send_mrs(rows[i][22:21], rows[i][20:5]);
      chk(rtt_nom, rows[i][4:2]);
      chk(rtt_wr, rows[i][1:0]);
      tick();
      chk(dyn_en, rows[i][1:0] != 2'h0);
    end
    // Turn-on, switch and return latencies
    foreach (runs[i]) begin
      {cwl, al} = runs[i][11:4];
      l = cwl + al - 2;
      repeat (2) tick();
      run(runs[i][3], runs[i][2:0], 1'b1, 1'b0);
    end
    // DLL off blocks strength switching
    dll_off = 1'b1;
    repeat (2) tick();
    chk(dyn_en, 1'b0);
    run(1'b0, 0, 1'b0, 1'b0);
    dll_off = 1'b0;
    // Self-refresh ignores the pin
    sr = 1'b1;
    run(1'b0, 0, 1'b0, 1'b1);
    sr = 1'b0;
    // Clearing the write field leaves only nominal strength
    send_mrs(2'h2, 16'h0000);
    tick();
    chk(dyn_en, 1'b0);
    run(1'b1, 0, 1'b0, 1'b0);
    // Reset in mid write
    send_mrs(2'h2, 16'h0200);
    go = 1'b1;
    repeat (5) tick();
    rstn_i = 1'b0;
    repeat (2) tick();
    rstn_i = 1'b1;
    go = 1'b0;
    tick();
    chk({rtt_en, rtt_sel_wr, dyn_en}, 3'h0);
    chk(rtt_nom | rtt_wr, 3'h0);
    end_sim();
  end
endmodule
`default_nettype wire
